/* File: hdl/ilt_pkg.sv */
package ilt_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
  // illumination times, in their printed units
  localparam int T_DOOR_S = 300;
  localparam int T_UNLOCK_S = 30;
  localparam int T_KEY_S = 15;
  localparam int T_CLOSE_S = 15;
  localparam int DOOR_TICKS = T_DOOR_S * 1000000 / TICK_US;
  localparam int UNLOCK_TICKS = T_UNLOCK_S * 1000000 / TICK_US;
  localparam int KEY_TICKS = T_KEY_S * 1000000 / TICK_US;
  localparam int CLOSE_TICKS = T_CLOSE_S * 1000000 / TICK_US;
  // switch filtering
  localparam int DEBOUNCE_MS = 20;
  localparam int DEB_TICKS = DEBOUNCE_MS * 1000 / TICK_US;
  // brightness, fade and pwm
  localparam logic [6:0] BRIGHT_OFF = 7'h00;
  localparam logic [6:0] BRIGHT_FULL = 7'h64;
  localparam logic [6:0] BRIGHT_DIM = 7'h3C;
  localparam int FADE_MS = 1000;
  localparam int FADE_STEP_TICKS = FADE_MS * 1000 / TICK_US / 100;
  localparam int PWM_STEP_NS = 100;
  localparam int PWM_DIV = PWM_STEP_NS / CLK_PERIOD_NS;
  localparam logic [6:0] PWM_STEPS = 7'h64;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_REMAIN = 4'h8;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_LEVEL_LSB = 4;
  localparam int ST_DOOR_BIT = 12;
  localparam int ST_SEL_BIT = 13;
  localparam int ST_IGN_BIT = 14;
  localparam int ST_KEY_BIT = 15;
  localparam int ST_UNL_BIT = 16;

  typedef enum {
    S_IDLE, S_DOOR, S_UNLOCK, S_KEY, S_CLOSE, S_REARM, S_TIMED_OUT
  } ilt_state_t;

  typedef struct packed {
    logic ign;
    logic key;
    logic unl;
    logic sel;
    logic door;
  } ilt_sw_t;
endpackage : ilt_pkg

/* File: hdl/ilt_debounce.sv */
`timescale 1ns/1ps
module ilt_debounce import ilt_pkg::*; #(
  parameter int W = 8,
  parameter int STABLE_TICKS = DEB_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sampling
  input wire logic tick,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] stable
);
  localparam int CW = $clog2(STABLE_TICKS + 1);
  logic [W-1:0] stable_ff;
  logic [W-1:0] nxt_stable;
  logic [CW-1:0] cnt_ff [W];
  logic [CW-1:0] nxt_cnt [W];

  if (W < 1 || STABLE_TICKS < 1) begin : g_chk
    $error("ilt_debounce: bad parameters");
  end

  // a change must persist for the whole window before it is believed
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_stable[i] = stable_ff[i];
      nxt_cnt[i] = cnt_ff[i];
      if (raw[i] == stable_ff[i]) begin
        nxt_cnt[i] = '0;
      end else if (tick) begin
        if (cnt_ff[i] == CW'(STABLE_TICKS - 1)) begin
          nxt_stable[i] = raw[i];
          nxt_cnt[i] = '0;
        end else begin
          nxt_cnt[i] = cnt_ff[i] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stable_ff <= '0;
      for (int i = 0; i < W; i++) cnt_ff[i] <= '0;
    end else begin
      stable_ff <= nxt_stable;
      for (int i = 0; i < W; i++) cnt_ff[i] <= nxt_cnt[i];
    end
  end

  assign stable = stable_ff;
endmodule : ilt_debounce

/* File: hdl/ilt_dimmer.sv */
`timescale 1ns/1ps
module ilt_dimmer import ilt_pkg::*; #(
  parameter int DIV = PWM_DIV,
  parameter int FADE_TICKS = FADE_STEP_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic [6:0] target,
  // lamp drive
  output logic [6:0] level,
  output logic pwm
);
  localparam int DW = $clog2(DIV + 1);
  localparam int FW = $clog2(FADE_TICKS + 1);
  logic [6:0] level_ff, nxt_level;
  logic [6:0] phase_ff, nxt_phase;
  logic [DW-1:0] div_ff, nxt_div;
  logic [FW-1:0] fade_ff, nxt_fade;
  logic pwm_ff, nxt_pwm;

  if (DIV < 1 || FADE_TICKS < 1) begin : g_chk
    $error("ilt_dimmer: bad parameters");
  end

  always_comb begin
    nxt_level = level_ff;
    nxt_fade = fade_ff;
    nxt_div = div_ff + DW'(1);
    nxt_phase = phase_ff;
    // rising brightness is immediate; falling is a slow fade
    if (target >= level_ff) begin
      nxt_level = target;
      nxt_fade = '0;
    end else if (tick) begin
      if (fade_ff == FW'(FADE_TICKS - 1)) begin
        nxt_fade = '0;
        nxt_level = level_ff - 7'h01;
      end else begin
        nxt_fade = fade_ff + FW'(1);
      end
    end
    if (div_ff == DW'(DIV - 1)) begin
      nxt_div = '0;
      nxt_phase = (phase_ff == PWM_STEPS - 7'h01) ? 7'h00 : phase_ff + 7'h01;
    end
    nxt_pwm = (phase_ff < level_ff);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_ff <= 7'h00;
      phase_ff <= 7'h00;
      div_ff <= '0;
      fade_ff <= '0;
      pwm_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      phase_ff <= nxt_phase;
      div_ff <= nxt_div;
      fade_ff <= nxt_fade;
      pwm_ff <= nxt_pwm;
    end
  end

  assign level = level_ff;
  assign pwm = pwm_ff;
endmodule : ilt_dimmer

/* File: hdl/ilt_top.sv */
`timescale 1ns/1ps
//Contract
//- automatic timing only with selector at door
//- door opens, ignition off: full, five minutes
//- door mode ends when doors close or timeout
//- unlock, key out, doors closed: full, thirty seconds
//- ignition, door open, relock or timeout cancel
//- key removed, doors closed: full, fifteen seconds
//- doors close while unlocked: dimmed, fifteen seconds
//- after timeout relight on reopen or ignition
module ilt_top import ilt_pkg::*; #(
  parameter int NUM_DOORS = 4,
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int DOOR_T = DOOR_TICKS,
  parameter int UNLOCK_T = UNLOCK_TICKS,
  parameter int KEY_T = KEY_TICKS,
  parameter int CLOSE_T = CLOSE_TICKS,
  parameter int TW = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // switches
  input wire logic ignition_run_feed,
  input wire logic key_in_lock,
  input wire logic lock_link_unlock,
  input wire logic lamp_sel_door,
  input wire logic [NUM_DOORS-1:0] door_sw,
  // lamp driver
  output logic lamp_pwm,
  output logic [6:0] lamp_level
);
  localparam int SW_W = 4 + NUM_DOORS;
  localparam int PW = $clog2(TICK_DIV + 1);

  if (NUM_DOORS < 1 || TICK_DIV < 1 || DOOR_T < 1 || UNLOCK_T < 1 || KEY_T < 1 || CLOSE_T < 1
      || DOOR_T >= 2 ** TW || UNLOCK_T >= 2 ** TW || KEY_T >= 2 ** TW || CLOSE_T >= 2 ** TW)
      begin : g_chk
    $error("ilt_top: bad parameters");
  end

  function automatic logic [TW-1:0] dur_of(input ilt_state_t s);
    case (s)
      S_DOOR: dur_of = TW'(DOOR_T);
      S_UNLOCK: dur_of = TW'(UNLOCK_T);
      S_KEY, S_REARM: dur_of = TW'(KEY_T);
      S_CLOSE: dur_of = TW'(CLOSE_T);
      default: dur_of = '0;
    endcase
  endfunction : dur_of

  function automatic logic [6:0] bright_of(input ilt_state_t s);
    case (s)
      S_DOOR, S_UNLOCK, S_KEY, S_REARM: bright_of = BRIGHT_FULL;
      S_CLOSE: bright_of = BRIGHT_DIM;
      default: bright_of = BRIGHT_OFF;
    endcase
  endfunction : bright_of

  // millisecond time base
  logic [PW-1:0] pre_ff, nxt_pre;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_tick = 1'b0;
    nxt_pre = pre_ff + PW'(1);
    if (pre_ff == PW'(TICK_DIV - 1)) begin
      nxt_pre = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      tick_ff <= nxt_tick;
    end
  end

  // switch filtering
  logic [SW_W-1:0] sw_clean;
  ilt_debounce #(.W(SW_W), .STABLE_TICKS(DEB_TICKS)) u_deb (
    .clk(clk),
    .rst(rst),
    .tick(tick_ff),
    .raw({ignition_run_feed, key_in_lock, lock_link_unlock, lamp_sel_door, door_sw}),
    .stable(sw_clean)
  );

  ilt_sw_t sw, sw_prev_ff;
  logic ignition_on_state;
  assign sw.ign = sw_clean[SW_W-1];
  assign sw.key = sw_clean[SW_W-2];
  assign sw.unl = sw_clean[SW_W-3];
  assign sw.sel = sw_clean[SW_W-4];
  assign sw.door = |sw_clean[NUM_DOORS-1:0];
  assign ignition_on_state = sw.ign;

  // registers
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wait_ff, nxt_wait;

  // state machine
  ilt_state_t state_ff, nxt_state;
  logic [TW-1:0] timer_ff, nxt_timer;
  logic trig_door, trig_unlock, trig_key, trig_close, cancel, expired, auto_on;

  always_comb begin
    auto_on = sw.sel && ctrl_ff[CTRL_EN_BIT];
    expired = (timer_ff == '0);
    // triggers are transitions qualified by a mix of the previous and the current switch picture
    trig_door = !ignition_on_state && !sw_prev_ff.door && sw.door;
    trig_unlock = !sw_prev_ff.key && !sw_prev_ff.door && !sw_prev_ff.unl && sw.unl;
    trig_key = sw_prev_ff.key && !sw.key && !sw_prev_ff.door && !sw.door;
    trig_close = !ignition_on_state && sw_prev_ff.door && !sw.door && sw.unl;
    cancel = ignition_on_state || (!sw_prev_ff.door && sw.door)
             || (sw_prev_ff.unl && !sw.unl);
    nxt_state = state_ff;
    nxt_timer = (tick_ff && !expired) ? timer_ff - TW'(1) : timer_ff;
    case (state_ff)
      S_IDLE, S_DOOR, S_UNLOCK, S_KEY, S_CLOSE: begin
        // door opening outranks the others; any new trigger restarts the time
        if (trig_door) nxt_state = S_DOOR;
        else if (trig_close) nxt_state = S_CLOSE;
        else if (trig_unlock) nxt_state = S_UNLOCK;
        else if (trig_key) nxt_state = S_KEY;
        else if (state_ff == S_DOOR && !sw.door) nxt_state = S_IDLE;
        else if (state_ff != S_IDLE && state_ff != S_DOOR && cancel) nxt_state = S_IDLE;
        else if (state_ff != S_IDLE && expired) nxt_state = S_TIMED_OUT;
        if (trig_door || trig_close || trig_unlock || trig_key) begin
          nxt_timer = dur_of(nxt_state);
        end
      end
      S_TIMED_OUT: begin
        // stays dark until a fresh reopen or ignition on
        if (!sw_prev_ff.door && sw.door) begin
          nxt_state = S_DOOR;
          nxt_timer = dur_of(S_DOOR);
        end else if (!sw_prev_ff.ign && sw.ign) begin
          nxt_state = S_REARM;
          nxt_timer = dur_of(S_REARM);
        end
      end
      S_REARM: begin
        if (!sw.ign) nxt_state = S_IDLE;
        else if (expired) nxt_state = S_TIMED_OUT;
      end
      default: nxt_state = S_IDLE;
    endcase
    if (!auto_on) begin
      nxt_state = S_IDLE;
      nxt_timer = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      timer_ff <= '0;
      sw_prev_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      sw_prev_ff <= sw;
    end
  end

  // lamp drive; off target fades out rather than cutting
  ilt_dimmer #(.DIV(PWM_DIV), .FADE_TICKS(FADE_STEP_TICKS)) u_dim (
    .clk(clk),
    .rst(rst),
    .tick(tick_ff),
    .target(bright_of(state_ff)),
    .level(lamp_level),
    .pwm(lamp_pwm)
  );

  // bus slave: one wait cycle, then the access completes
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[ST_STATE_LSB +: 3] = 3'(state_ff);
    status_word[ST_LEVEL_LSB +: 7] = lamp_level;
    status_word[ST_DOOR_BIT] = sw.door;
    status_word[ST_SEL_BIT] = sw.sel;
    status_word[ST_IGN_BIT] = sw.ign;
    status_word[ST_KEY_BIT] = sw.key;
    status_word[ST_UNL_BIT] = sw.unl;
    nxt_wait = !((avs_read || avs_write) && wait_ff);
    nxt_rdata = rdata_ff;
    if (avs_read && wait_ff) begin
      case (avs_address)
        REG_CTRL: nxt_rdata = ctrl_ff;
        REG_STATUS: nxt_rdata = status_word;
        REG_REMAIN: nxt_rdata = 32'(timer_ff);
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_ctrl = ctrl_ff;
    if (avs_write && !wait_ff && avs_address == REG_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) nxt_ctrl[8*b +: 8] = avs_writedata[8*b +: 8];
      end
      nxt_ctrl[31:1] = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;
      rdata_ff <= '0;
      wait_ff <= 1'b1;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      wait_ff <= nxt_wait;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
endmodule : ilt_top

/* File: dv/ilt_switch_model.sv */
`timescale 1ns/1ps
module ilt_switch_model import ilt_pkg::*; (
  // wanted positions
  input wire ilt_sw_t want,
  // switch contacts
  output logic ignition_run_feed,
  output logic key_in_lock,
  output logic lock_link_unlock,
  output logic lamp_sel_door,
  output logic [3:0] door_sw
);
  // clean contacts: no bounce is modelled here
  always_comb begin
    ignition_run_feed = want.ign;
    key_in_lock = want.key;
    lock_link_unlock = want.unl;
    lamp_sel_door = want.sel;
    // a rear door, so any-door logic is not only door 0
    door_sw = {1'b0, want.door, 2'h0};
  end
endmodule : ilt_switch_model

/* File: dv/ilt_top_props.sv */
`timescale 1ns/1ps
module ilt_top_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // lamp driver
  input wire logic lamp_pwm,
  input wire logic [6:0] lamp_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_hole_zero: assert property (
    avs_read && avs_waitrequest && avs_address == 4'hC |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_bits: assert property (
    avs_read && avs_waitrequest && avs_address == 4'h0 |=> avs_readdata[31:1] == 31'h0)
    else $error("ctrl upper bits set");
  a_reset_dark: assert property (disable iff (1'b0)
    rst |=> lamp_level == 7'h00 && avs_waitrequest && !lamp_pwm)
    else $error("reset state wrong");
  a_level_cap: assert property (lamp_level <= 7'h64)
    else $error("level above full");
  a_no_cut: assert property (lamp_level == 7'h64 |=> lamp_level != 7'h00)
    else $error("lamp cut abruptly");
  a_fade_hold: assert property (
    lamp_level < $past(lamp_level) |=> (lamp_level >= $past(lamp_level)) [*8])
    else $error("fade steps too fast");
  a_pwm_full: assert property (lamp_level == 7'h64 [*3] |-> lamp_pwm)
    else $error("full lamp not on");
  a_pwm_dark: assert property (lamp_level == 7'h00 [*3] |-> !lamp_pwm)
    else $error("dark lamp driven");
endmodule : ilt_top_props
bind ilt_top ilt_top_props u_ilt_top_props (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .lamp_pwm(lamp_pwm), .lamp_level(lamp_level));

/* File: dv/ilt_top_tb_top.sv */
`timescale 1ns/1ps
module ilt_top_tb_top import ilt_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd_r = 1'b0;
  logic wr_r = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat, rq;
  logic wreq, ign, key, unl, sel, pwm;
  logic [3:0] door;
  logic [6:0] lvl;
  ilt_sw_t want = '0;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  ilt_switch_model u_ilt_switch_model (.want(want), .ignition_run_feed(ign),
    .key_in_lock(key), .lock_link_unlock(unl), .lamp_sel_door(sel), .door_sw(door));
  // short timers keep the run small; close time long enough to see the dim level
  // unlock time outlasts the 20-tick filter, so a relock is seen before the timeout
  ilt_top #(.TICK_DIV(10), .DOOR_T(50), .UNLOCK_T(40), .KEY_T(10), .CLOSE_T(600))
  u_ilt_top (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_r), .avs_write(wr_r),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .ignition_run_feed(ign), .key_in_lock(key),
    .lock_link_unlock(unl), .lamp_sel_door(sel), .door_sw(door), .lamp_pwm(pwm),
    .lamp_level(lvl));
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    rd_r <= !w;
    wr_r <= w;
    @(posedge clk);
    // no cycle count assumed; only the bench timeout ends a wait that never closes
    while (wreq !== 1'b0) @(posedge clk);
    rq = rdat;
    chk("answer", 32'h0, {31'h0, wreq});
    rd_r <= 1'b0;
    wr_r <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic st(input logic [2:0] e);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("state", {29'h0, e}, {29'h0, rq[2:0]});
  endtask : st
  task automatic lv(input logic [6:0] e);
    chk("level", {25'h0, e}, {25'h0, lvl});
  endtask : lv
  // filter needs 20 ms-ticks of 10 cycles, 230 covers tick phase
  task automatic rst_dut(input logic s);
    want <= '{ign: 1'b0, key: 1'b0, unl: 1'b0, sel: s, door: 1'b0};
    rst <= 1'b1;
    wt(3);
    rst <= 1'b0;
    wt(230);
  endtask : rst_dut
  task automatic t_regs;
    rst_dut(1'b1);
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", CTRL_RESET, rq);
    bus(1'b0, 4'hC, 32'h0);
    chk("hole", 32'h0, rq);
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h0, rq);
    // lane 0 gated off: the enable bit must not move
    be <= 4'hE;
    bus(1'b1, REG_CTRL, 32'h0000_0001);
    be <= 4'hF;
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_lane", 32'h0, rq);
    want.door <= 1'b1;
    wt(230);
    st(3'h0);
  endtask : t_regs
  task automatic t_door;
    rst_dut(1'b1);
    want.door <= 1'b1;
    wt(230);
    st(3'h1);
    lv(BRIGHT_FULL);
    want.door <= 1'b0;
    wt(230);
    st(3'h0);
    rst_dut(1'b0);
    want.door <= 1'b1;
    wt(230);
    st(3'h0);
    lv(BRIGHT_OFF);
  endtask : t_door
  task automatic t_unlock;
    rst_dut(1'b1);
    want.unl <= 1'b1;
    wt(230);
    st(3'h2);
    lv(BRIGHT_FULL);
    want.unl <= 1'b0;
    wt(230);
    st(3'h0);
    want.unl <= 1'b1;
    wt(230);
    st(3'h2);
    want.ign <= 1'b1;
    wt(230);
    st(3'h0);
  endtask : t_unlock
  task automatic t_key;
    rst_dut(1'b1);
    want.key <= 1'b1;
    wt(230);
    want.key <= 1'b0;
    wt(230);
    st(3'h3);
    lv(BRIGHT_FULL);
    wt(120);
    st(3'h6);
    bus(1'b0, REG_REMAIN, 32'h0);
    chk("remain", 32'h0, rq);
  endtask : t_key
  task automatic t_rearm;
    rst_dut(1'b1);
    want.unl <= 1'b1;
    wt(700);
    st(3'h6);
    want.ign <= 1'b1;
    wt(230);
    st(3'h5);
    lv(BRIGHT_FULL);
    rst_dut(1'b1);
    want.door <= 1'b1;
    wt(760);
    st(3'h6);
    want.door <= 1'b0;
    wt(230);
    want.door <= 1'b1;
    wt(230);
    st(3'h1);
  endtask : t_rearm
  task automatic t_close;
    int hi;
    hi = 0;
    rst_dut(1'b1);
    want.unl <= 1'b1;
    want.door <= 1'b1;
    wt(230);
    st(3'h1);
    want.door <= 1'b0;
    wt(230);
    st(3'h4);
    wt(4500);
    lv(BRIGHT_DIM);
    // one whole pwm period at the steady dim level
    repeat (PWM_STEPS * PWM_DIV) begin
      @(posedge clk);
      if (pwm === 1'b1) hi++;
    end
    chk("pwm_on", BRIGHT_DIM * PWM_DIV, hi);
  endtask : t_close
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    t_regs();
    t_door();
    t_unlock();
    t_key();
    t_rearm();
    t_close();
    tally_and_finish();
  end
endmodule : ilt_top_tb_top
